// ---- sfc_pkg.sv ----
// Shared constants for the serial flash command link
// ------------------------------------------------------------
// Functional notes
// ------------------------------------------------------------
// Functional notes
// - 55H with zero address copies program buffer
// - Host gives 16 control clocks, raises select
// - Both buffers locked, transfer flag during copy
// - Host never transfers while device busy
// - Config read: zero address, then config field
// - Only low nine config bits are used
// - Config picks pin, edge, protect, oscillator
// - Config cells survive power loss
// - Host reads config, skips needless write
// - Config write: 8AH, field, 16 zero clocks
// - Host zeroes reserved config bits
// - Busy for program time after config write
// - Status read: zero address, busy, status
// - Status: ready, transfer, write enable, mismatch
// - Compare difference sets mismatch flag
// - Only 89H clears mismatch flag
// - Read-only information sector describes part
// - Good sector byte zero holds C9H
// - Restricted sector byte zero differs from C9H
// - Host keeps sector tag byte intact
// - Compare output one means bits match
package sfc_pkg;
    localparam logic [7:0] OP_PB_TO_SRAM = 8'h55;
    localparam logic [7:0] OP_WR_CFG = 8'h8A;
    localparam logic [7:0] OP_CLR_CMP = 8'h89;
    localparam logic [7:0] OP_RD_CFG = 8'h8B;
    localparam logic [7:0] OP_RD_STAT = 8'h57;
    localparam logic [7:0] OP_RD_INFO = 8'h5F;
    localparam logic [7:0] OP_CMP = 8'h60;
    // Bit positions within a frame, counted in received clocks
    localparam logic [9:0] POS_OP_LAST = 10'h007;
    localparam logic [9:0] POS_SECT_LAST = 10'h017;
    localparam logic [9:0] POS_BADDR_LAST = 10'h027;
    localparam logic [9:0] POS_RB = 10'h038;
    localparam logic [9:0] POS_FIELD = 10'h048;
    localparam logic [9:0] END_ST = 10'h050;
    localparam logic [9:0] END_CF = 10'h058;
    localparam logic [9:0] LEN_CLR = 10'h008;
    localparam logic [9:0] LEN_WR_CFG = 10'h028;
    localparam logic [9:0] LEN_XFER = 10'h038;
    localparam logic [9:0] LEN_READ = 10'h058;
    localparam logic [9:0] LEN_STAT = 10'h050;
    localparam logic [8:0] BUF_LAST = 9'h107;
    localparam logic [7:0] TAG_OK = 8'hC9;
    localparam logic [7:0] TAG_BAD = 8'h00;
    localparam logic [7:0] ERASED = 8'hFF;
    localparam int ST_RDY = 0;
    localparam int ST_TR = 1;
    localparam int ST_WE = 2;
    localparam int ST_CNE = 3;
    localparam int CF_HOLD_RB = 0;
    localparam int CF_RD_EDGE = 1;
    localparam int CF_WP_LO = 2;
    localparam int CF_ALT_OSC = 8;
    localparam logic [8:0] CFG_FACTORY = 9'h000;
    // Information sector contents; values are arbitrary
    localparam logic [7:0] INFO_PART = 8'h5A;
    localparam logic [7:0] INFO_DENS = 8'h01;
    localparam logic [7:0] INFO_VOLT = 8'h03;
    localparam logic [7:0] INFO_TEMP = 8'h00;
    localparam logic [7:0] INFO_PKG = 8'h01;
    localparam logic [7:0] INFO_OPT = 8'h00;
    localparam int CLK_MHZ = 100;
    localparam int CLK_PER_NS = 10;
    localparam int TXP_US = 100;
    localparam int TWP_MS = 10;
    localparam int TXP_CYC_DEF = TXP_US * CLK_MHZ;
    localparam int TWP_CYC_DEF = TWP_MS * 1000 * CLK_MHZ;
    localparam int SCK_PER_NS = 160;
    localparam logic [7:0] SCK_HALF = 8'(SCK_PER_NS / 2 / CLK_PER_NS);
    localparam logic [7:0] A_CTRL = 8'h00;
    localparam logic [7:0] A_ADDR = 8'h04;
    localparam logic [7:0] A_CFGW = 8'h08;
    localparam logic [7:0] A_STAT = 8'h0C;
    localparam logic [7:0] A_RDATA = 8'h10;
    localparam int CTRL_GO = 8;
endpackage : sfc_pkg

// ---- sfc_if.sv ----
// Four-wire serial link plus ready/busy line between flash host and device
`timescale 1ns/1ns
interface sfc_if;
    logic sck;
    logic cs_n;
    logic si;
    logic so_d;
    logic so_oe;
    logic rdybsy;
    logic so;
    // Undriven serial output floats high through a pull-up
    assign so = so_oe ? so_d : 1'b1;
    modport dev (input sck, input cs_n, input si, output so_d, output so_oe, output rdybsy);
    modport host (input so, input rdybsy, output sck, output cs_n, output si);
endinterface : sfc_if

// ---- sfc_device.sv ----
// Flash device end: command decoder, status, config cells, buffers
`timescale 1ns/1ns
module sfc_device
    import sfc_pkg::*;
#(
    parameter int TXP_CYC = TXP_CYC_DEF,
    parameter int TWP_CYC = TWP_CYC_DEF,
    parameter logic [15:0] BAD_SECTOR = 16'h0005
)
(
    input wire logic clk,
    input wire logic rst,
    sfc_if.dev link,
    input wire logic pbuf_we,
    input wire logic [8:0] pbuf_addr,
    input wire logic [7:0] pbuf_data,
    output logic hold_rb_sel,
    output logic read_edge_rise,
    output logic [5:0] wp_range,
    output logic alt_osc,
    output logic busy
);
    logic [2:0] sck_s;
    logic [2:0] cs_s;
    logic [1:0] si_s;
    logic sck_rise;
    logic sck_fall;
    logic cs_rise;
    logic [9:0] cnt_r;
    logic [15:0] sr_r;
    logic [15:0] sr_nxt;
    logic [7:0] op_r;
    logic [15:0] sect_r;
    logic [15:0] baddr_r;
    logic [8:0] ptr_r;
    logic [2:0] bit_r;
    logic [9:0] fidx;
    logic so_r;
    logic so_oe_r;
    logic busy_r;
    logic rdy_r;
    logic tr_r;
    logic prog_r;
    logic [19:0] tmr_r;
    logic [8:0] pend_r;
    logic [8:0] cfg_cells_r = CFG_FACTORY;
    logic mis_r;
    logic mis_set;
    logic mis_clr;
    logic in_data;
    logic start_xfer;
    logic start_prog;
    logic cmp_bit;
    logic [7:0] ref_byte;
    logic [7:0] info_cur;
    logic [7:0] status_byte;
    logic [15:0] cfg_word;
    logic [7:0] sram [0:511];
    logic [7:0] pbuf [0:511];

    // Factory content of a sector: tag byte, then erased cells
    function automatic logic [7:0] sector_byte(input logic [15:0] s, input logic [8:0] a);
        if (a != 9'h000)
            return ERASED;
        else if (s == BAD_SECTOR)
            return TAG_BAD;
        else
            return TAG_OK;
    endfunction : sector_byte

    function automatic logic [7:0] info_byte(input logic [8:0] a);
        case (a)
            9'h000: return INFO_PART;
            9'h001: return INFO_DENS;
            9'h002: return INFO_VOLT;
            9'h003: return INFO_TEMP;
            9'h004: return INFO_PKG;
            9'h005: return INFO_OPT;
            9'h006: return BAD_SECTOR[15:8];
            9'h007: return BAD_SECTOR[7:0];
            default: return ERASED;
        endcase
    endfunction : info_byte

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            sck_s <= 3'h0;
            cs_s <= 3'h7;
            si_s <= 2'h0;
        end
        else
        begin
            sck_s <= {sck_s[1:0], link.sck};
            cs_s <= {cs_s[1:0], link.cs_n};
            si_s <= {si_s[0], link.si};
        end
    end

    assign sck_rise = sck_s[1] & ~sck_s[2];
    assign sck_fall = ~sck_s[1] & sck_s[2];
    assign cs_rise = cs_s[1] & ~cs_s[2];
    assign sr_nxt = {sr_r[14:0], si_s[1]};
    assign fidx = cnt_r - POS_FIELD;
    assign in_data = sck_fall & ~cs_s[1] & (cnt_r >= POS_RB);

    // ------------------------------------------------------------
    // Frame capture
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            cnt_r <= 10'h000;
            sr_r <= 16'h0000;
            op_r <= 8'h00;
            sect_r <= 16'h0000;
            baddr_r <= 16'h0000;
        end
        else if (cs_s[1])
            cnt_r <= 10'h000;
        else if (sck_rise)
        begin
            sr_r <= sr_nxt;
            if (cnt_r != 10'h3FF)
                cnt_r <= cnt_r + 10'h001;
            if (cnt_r == POS_OP_LAST)
                op_r <= sr_nxt[7:0];
            if (cnt_r == POS_SECT_LAST)
                sect_r <= sr_nxt;
            if (cnt_r == POS_BADDR_LAST)
                baddr_r <= sr_nxt;
        end
    end

    // Byte pointer for information and compare data, wraps after the last byte
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            ptr_r <= 9'h000;
            bit_r <= 3'h0;
        end
        else if (sck_rise && !cs_s[1] && cnt_r == POS_BADDR_LAST)
        begin
            ptr_r <= (sr_nxt[15:9] == 7'h00 && sr_nxt[8:0] <= BUF_LAST) ? sr_nxt[8:0] : 9'h000;
            bit_r <= 3'h0;
        end
        else if (in_data)
        begin
            bit_r <= bit_r + 3'h1;
            if (bit_r == 3'h7)
                ptr_r <= (ptr_r == BUF_LAST) ? 9'h000 : ptr_r + 9'h001;
        end
    end

    // ------------------------------------------------------------
    // Status and compare
    // ------------------------------------------------------------
    always_comb
    begin
        status_byte = 8'h00;
        status_byte[ST_RDY] = ~busy_r;
        status_byte[ST_TR] = tr_r;
        status_byte[ST_WE] = (cfg_cells_r[CF_ALT_OSC-1:CF_WP_LO] == 6'h00);
        status_byte[ST_CNE] = mis_r;
    end

    assign cfg_word = {7'h00, cfg_cells_r};
    assign ref_byte = sector_byte(sect_r, ptr_r);
    assign info_cur = info_byte(ptr_r);
    assign cmp_bit = (sram[ptr_r][3'h7 - bit_r] == ref_byte[3'h7 - bit_r]);
    assign mis_set = in_data & (op_r == OP_CMP) & ~cmp_bit;
    assign mis_clr = cs_rise & (op_r == OP_CLR_CMP) & (cnt_r >= LEN_CLR);

    // A mismatch seen in the clearing cycle still sticks
    always_ff @(posedge clk)
    begin
        if (rst)
            mis_r <= 1'b0;
        else
            mis_r <= mis_set | (mis_r & ~mis_clr);
    end

    // ------------------------------------------------------------
    // Serial output
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            so_r <= 1'b1;
            so_oe_r <= 1'b0;
        end
        else if (cs_s[1])
        begin
            so_r <= 1'b1;
            so_oe_r <= 1'b0;
        end
        else if (sck_fall && cnt_r >= POS_RB)
        begin
            case (op_r)
                OP_RD_STAT:
                begin
                    so_oe_r <= 1'b1;
                    if (cnt_r < POS_FIELD)
                        so_r <= ~busy_r;
                    else
                        so_r <= (cnt_r < END_ST) & status_byte[3'h7 - fidx[2:0]];
                end
                OP_RD_CFG:
                begin
                    so_oe_r <= 1'b1;
                    if (cnt_r < POS_FIELD)
                        so_r <= ~busy_r;
                    else
                        so_r <= (cnt_r < END_CF) & cfg_word[4'hF - fidx[3:0]];
                end
                OP_RD_INFO:
                begin
                    so_oe_r <= 1'b1;
                    so_r <= info_cur[3'h7 - bit_r];
                end
                OP_CMP:
                begin
                    so_oe_r <= 1'b1;
                    so_r <= cmp_bit;
                end
                default:
                begin
                    so_oe_r <= 1'b0;
                    so_r <= 1'b1;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // Transfer and config programming engine
    // ------------------------------------------------------------
    // A transfer is refused unless idle and given an all-zero address
    assign start_xfer = cs_rise & (op_r == OP_PB_TO_SRAM) & (cnt_r >= LEN_XFER)
        & ~busy_r & (sect_r == 16'h0000) & (baddr_r == 16'h0000);
    assign start_prog = cs_rise & (op_r == OP_WR_CFG) & (cnt_r >= LEN_WR_CFG) & ~busy_r;

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            tr_r <= 1'b0;
            prog_r <= 1'b0;
            tmr_r <= 20'h0_0000;
            pend_r <= 9'h000;
        end
        else
        begin
            if (start_xfer)
            begin
                tr_r <= 1'b1;
                tmr_r <= 20'h0_0000;
            end
            else if (start_prog)
            begin
                prog_r <= 1'b1;
                pend_r <= sect_r[8:0];
                tmr_r <= 20'h0_0000;
            end
            else if (tr_r || prog_r)
            begin
                tmr_r <= tmr_r + 20'h0_0001;
                if (tr_r && tmr_r == 20'(TXP_CYC - 1))
                    tr_r <= 1'b0;
                if (prog_r && tmr_r == 20'(TWP_CYC - 1))
                    prog_r <= 1'b0;
            end
        end
    end

    // Cells keep their value through rst, only power-up loads the default
    always_ff @(posedge clk)
    begin
        if (prog_r && tmr_r == 20'(TWP_CYC - 1))
            cfg_cells_r <= pend_r;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            for (int i = 0; i < 512; i++)
                sram[i] <= ERASED;
        end
        else if (start_xfer)
        begin
            // Whole buffer moves in one edge, so the flag always outlasts the copy
            for (int i = 0; i <= int'(BUF_LAST); i++)
                sram[i] <= pbuf[i];
        end
    end

    // Program buffer is locked while a transfer runs
    always_ff @(posedge clk)
    begin
        if (pbuf_we && !tr_r && pbuf_addr <= BUF_LAST)
            pbuf[pbuf_addr] <= pbuf_data;
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            busy_r <= 1'b0;
            rdy_r <= 1'b1;
        end
        else
        begin
            busy_r <= tr_r | prog_r | start_xfer | start_prog;
            rdy_r <= ~(tr_r | prog_r | start_xfer | start_prog);
        end
    end

    assign link.so_d = so_r;
    assign link.so_oe = so_oe_r;
    assign link.rdybsy = rdy_r;
    assign busy = busy_r;
    assign hold_rb_sel = cfg_cells_r[CF_HOLD_RB];
    assign read_edge_rise = cfg_cells_r[CF_RD_EDGE];
    assign wp_range = cfg_cells_r[CF_ALT_OSC-1:CF_WP_LO];
    assign alt_osc = cfg_cells_r[CF_ALT_OSC];
endmodule : sfc_device

// ---- sfc_host.sv ----
// Flash host end: APB command registers driving the serial link
`timescale 1ns/1ns
module sfc_host
    import sfc_pkg::*;
(
    input wire logic clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    sfc_if.host link
);
    typedef enum logic [4:0] {
        S_IDLE = 5'b00001,
        S_WRDY = 5'b00010,
        S_LEAD = 5'b00100,
        S_SHIFT = 5'b01000,
        S_LAG = 5'b10000
    } sfc_state_t;

    sfc_state_t state_r;
    logic [1:0] so_s;
    logic [1:0] rdy_s;
    logic [31:0] prdata_r;
    logic pready_r;
    logic pslverr_r;
    logic [31:0] rd_val;
    logic rd_err;
    logic wr_en;
    logic go;
    logic [7:0] op_r;
    logic [15:0] sect_r;
    logic [15:0] baddr_r;
    logic [8:0] cfgw_r;
    logic need_rdy_r;
    logic done_r;
    logic skip_r;
    logic [31:0] rdata_r;
    logic [8:0] seen_r;
    logic seen_v_r;
    logic [7:0] div_r;
    logic tick;
    logic [9:0] bits_r;
    logic [9:0] len_r;
    logic [55:0] tx_r;
    logic [31:0] rx_r;
    logic sck_r;
    logic cs_n_r;
    logic si_r;

    function automatic logic [9:0] frame_len(input logic [7:0] op);
        case (op)
            OP_WR_CFG: return LEN_WR_CFG;
            OP_CLR_CMP: return LEN_CLR;
            OP_RD_STAT: return LEN_STAT;
            OP_RD_CFG, OP_RD_INFO, OP_CMP: return LEN_READ;
            default: return LEN_XFER;
        endcase
    endfunction : frame_len

    // ------------------------------------------------------------
    // APB slave, one wait-free access phase
    // ------------------------------------------------------------
    always_comb
    begin
        rd_err = 1'b0;
        case (paddr)
            A_CTRL: rd_val = {24'h00_0000, op_r};
            A_ADDR: rd_val = {sect_r, baddr_r};
            A_CFGW: rd_val = {23'h00_0000, cfgw_r};
            A_STAT: rd_val = {28'h000_0000, ~rdy_s[1], skip_r, done_r, state_r != S_IDLE};
            A_RDATA: rd_val = rdata_r;
            default:
            begin
                rd_val = 32'h0000_0000;
                rd_err = 1'b1;
            end
        endcase
    end

    assign wr_en = psel & penable & pready_r & pwrite;
    assign go = wr_en & (paddr == A_CTRL) & pwdata[CTRL_GO] & (state_r == S_IDLE);
    assign tick = (div_r == SCK_HALF - 8'h01);

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            pready_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pslverr_r <= 1'b0;
        end
        else
        begin
            pready_r <= psel & ~penable;
            if (psel && !penable)
            begin
                prdata_r <= rd_val;
                pslverr_r <= rd_err;
            end
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            op_r <= 8'h00;
            sect_r <= 16'h0000;
            baddr_r <= 16'h0000;
            cfgw_r <= 9'h000;
        end
        else if (wr_en)
        begin
            if (paddr == A_CTRL && state_r == S_IDLE)
                op_r <= pwdata[7:0];
            if (paddr == A_ADDR)
                {sect_r, baddr_r} <= pwdata;
            if (paddr == A_CFGW)
                cfgw_r <= pwdata[8:0];
        end
    end

    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            so_s <= 2'h3;
            rdy_s <= 2'h0;
        end
        else
        begin
            so_s <= {so_s[0], link.so};
            rdy_s <= {rdy_s[0], link.rdybsy};
        end
    end

    // ------------------------------------------------------------
    // Frame sequencer
    // ------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (rst)
        begin
            state_r <= S_IDLE;
            {sck_r, cs_n_r, si_r} <= 3'h2;
            div_r <= 8'h00;
            bits_r <= 10'h000;
            len_r <= 10'h000;
            tx_r <= 56'h00_0000_0000_0000;
            rx_r <= 32'h0000_0000;
            {need_rdy_r, done_r, skip_r, seen_v_r} <= 4'h0;
            rdata_r <= 32'h0000_0000;
            seen_r <= 9'h000;
        end
        else
        begin
            div_r <= (tick || state_r == S_IDLE || state_r == S_WRDY) ? 8'h00 : div_r + 8'h01;
            case (state_r)
                S_IDLE:
                    if (go)
                    begin
                        done_r <= 1'b0;
                        skip_r <= 1'b0;
                        if (pwdata[7:0] == OP_WR_CFG && seen_v_r && seen_r == cfgw_r)
                        begin
                            done_r <= 1'b1;
                            skip_r <= 1'b1;
                        end
                        else
                        begin
                            if (pwdata[7:0] == OP_WR_CFG)
                                tx_r <= {OP_WR_CFG, 7'h00, cfgw_r, 32'h0000_0000};
                            else
                                tx_r <= {pwdata[7:0], sect_r, baddr_r, 16'h0000};
                            len_r <= frame_len(pwdata[7:0]);
                            need_rdy_r <= (pwdata[7:0] == OP_PB_TO_SRAM) || (pwdata[7:0] == OP_WR_CFG);
                            bits_r <= 10'h000;
                            state_r <= S_WRDY;
                        end
                    end
                S_WRDY:
                    if (rdy_s[1] || !need_rdy_r)
                    begin
                        cs_n_r <= 1'b0;
                        si_r <= tx_r[55];
                        state_r <= S_LEAD;
                    end
                S_LEAD:
                    if (tick)
                    begin
                        sck_r <= 1'b1;
                        rx_r <= {rx_r[30:0], so_s[1]};
                        bits_r <= bits_r + 10'h001;
                        state_r <= S_SHIFT;
                    end
                S_SHIFT:
                    if (tick && sck_r)
                    begin
                        sck_r <= 1'b0;
                        tx_r <= {tx_r[54:0], 1'b0};
                        si_r <= tx_r[54];
                        if (bits_r == len_r)
                            state_r <= S_LAG;
                    end
                    else if (tick)
                    begin
                        sck_r <= 1'b1;
                        rx_r <= {rx_r[30:0], so_s[1]};
                        bits_r <= bits_r + 10'h001;
                    end
                S_LAG:
                    if (tick)
                    begin
                        cs_n_r <= 1'b1;
                        done_r <= 1'b1;
                        rdata_r <= rx_r;
                        state_r <= S_IDLE;
                        if (op_r == OP_RD_CFG)
                        begin
                            seen_r <= rx_r[8:0];
                            seen_v_r <= 1'b1;
                        end
                        else if (op_r == OP_WR_CFG)
                        begin
                            seen_r <= cfgw_r;
                            seen_v_r <= 1'b1;
                        end
                    end
                default:
                    state_r <= S_IDLE;
            endcase
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign link.sck = sck_r;
    assign link.cs_n = cs_n_r;
    assign link.si = si_r;
endmodule : sfc_host

// ---- sfc_link_asserts.sv ----
// Link timing checks for the flash host/device pair
`timescale 1ns/1ns
module sfc_link_asserts (
    input wire logic clk,
    input wire logic rst,
    input wire logic sck,
    input wire logic cs_n,
    input wire logic si,
    input wire logic so_d,
    input wire logic so_oe,
    input wire logic rdybsy
);
    // ----
    // Frame timing
    // ----
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence s_hi; sck [*8]; endsequence
    sequence s_bsy; !rdybsy [*8]; endsequence
    property p_hi; $rose(sck) |-> s_hi ##1 !sck; endproperty
    a_hi: assert property (p_hi) else $error("sck high time");
    property p_lead; $fell(cs_n) |-> !sck [*8]; endproperty
    a_lead: assert property (p_lead) else $error("select lead");
    property p_idle; cs_n |-> !sck; endproperty
    a_idle: assert property (p_idle) else $error("sck outside frame");
    property p_si; sck && $past(sck) |-> $stable(si); endproperty
    a_si: assert property (p_si) else $error("si moved");
    property p_so; so_oe && sck && $past(sck) |-> $stable(so_d); endproperty
    a_so: assert property (p_so) else $error("so moved");
    // Output must float soon after deselect or it fights the next frame
    property p_off; $rose(cs_n) |-> ##[1:8] !so_oe; endproperty
    a_off: assert property (p_off) else $error("so not released");
    property p_bsel; $fell(rdybsy) |-> cs_n; endproperty
    a_bsel: assert property (p_bsel) else $error("busy in frame");
    property p_blen; $fell(rdybsy) |=> s_bsy ##[20:60] rdybsy; endproperty
    a_blen: assert property (p_blen) else $error("busy length");
endmodule : sfc_link_asserts

// ---- serial_flash_config_status_cmds_bench.sv ----
// Bench: APB host driving the flash device over the link
`timescale 1ns/1ns
module serial_flash_config_status_cmds_bench;
    import sfc_pkg::*;
    logic clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, pbuf_we = 0;
    logic pready, pslverr, hold_rb_sel, read_edge_rise, alt_osc, busy;
    logic [5:0] wp_range;
    logic [7:0] paddr = '0, pbuf_data = '0;
    logic [8:0] pbuf_addr = '0, cfg;
    logic [31:0] pwdata = '0, prdata, rd, st;
    int num_errors = 0, n_tests = 0, seed = 32'h49a8_8393, pb[264];
    always #5 clk = ~clk;
    sfc_if link ();
    sfc_host u_sfc_host (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .link);
    sfc_device #(.TXP_CYC(50), .TWP_CYC(40)) u_sfc_device (.clk, .rst, .link, .pbuf_we,
        .pbuf_addr, .pbuf_data, .hold_rb_sel, .read_edge_rise, .wp_range, .alt_osc, .busy);
    sfc_link_asserts u_chk (.clk, .rst, .sck(link.sck), .cs_n(link.cs_n), .si(link.si),
        .so_d(link.so_d), .so_oe(link.so_oe), .rdybsy(link.rdybsy));
    // ----
    // Tasks
    // ----
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            num_errors++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask : apb
    // Polls status until done, keeps it in st, then fetches the shifted-in bits
    task automatic cmd(input logic [7:0] op, input logic [31:0] ad);
        int i;
        i = 0;
        apb(1'b1, A_ADDR, ad);
        apb(1'b1, A_CTRL, {23'h0, 1'b1, op});
        do
        begin
            apb(1'b0, A_STAT, '0);
            i++;
        end while (rd[1:0] !== 2'b10 && i < 4000);
        if (i >= 4000)
        begin
            num_errors++;
            end_of_test();
        end
        st = rd;
        apb(1'b0, A_RDATA, '0);
    endtask : cmd
    task automatic busy_span;
        repeat (8) @(posedge clk);
        chk(busy, 1'b1);
        repeat (60) @(posedge clk);
    endtask : busy_span
    task automatic end_of_test;
        $display("checks %0d errors %0d", n_tests, num_errors);
        if (num_errors == 0 && n_tests > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask : end_of_test
    initial
    begin
        #900000;
        num_errors++;
        end_of_test();
    end
    initial
    begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        apb(1'b0, 8'h14, '0);
        chk({rd[30:0], pslverr}, 32'h1);
        cfg = 9'($random(seed));
        apb(1'b1, A_CFGW, {23'($random(seed)), cfg});
        cmd(OP_WR_CFG, '0);
        chk(st[2:0], 3'b010);
        busy_span();
        chk({alt_osc, wp_range, read_edge_rise, hold_rb_sel}, cfg);
        // Mid-run reset must leave the config cells untouched
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({alt_osc, wp_range, read_edge_rise, hold_rb_sel}, cfg);
        cmd(OP_RD_CFG, '0);
        chk(rd, {16'hffff, 7'h0, cfg});
        apb(1'b1, A_CFGW, {23'h0, cfg});
        cmd(OP_WR_CFG, '0);
        chk(st[2:0], 3'b110);
        cmd(OP_RD_STAT, '0);
        chk(rd[23:0], {16'hffff, 5'h0, cfg[7:2] == 6'h0, 2'b01});
        cmd(OP_RD_INFO, '0);
        chk(rd, {INFO_PART, INFO_DENS, INFO_VOLT, INFO_TEMP});
        cmd(OP_CMP, 32'h0005_0000);
        chk(rd, {~(TAG_BAD ^ ERASED), 24'hff_ffff});
        cmd(OP_RD_STAT, '0);
        chk(rd[3], 1'b1);
        cmd(OP_CLR_CMP, '0);
        cmd(OP_RD_STAT, '0);
        chk(rd[3], 1'b0);
        for (int i = 0; i < 264; i++)
        begin
            pb[i] = $random(seed) & 255;
            pbuf_we <= 1'b1;
            pbuf_addr <= 9'(i);
            pbuf_data <= 8'(pb[i]);
            @(posedge clk);
        end
        pbuf_we <= 1'b0;
        cmd(OP_PB_TO_SRAM, '0);
        busy_span();
        cmd(OP_CMP, 32'h0001_0000);
        chk(rd, {~(TAG_OK ^ 8'(pb[0])), 8'(pb[1]), 8'(pb[2]), 8'(pb[3])});
        end_of_test();
    end
endmodule : serial_flash_config_status_cmds_bench
